// ---- pmc_power_mode_controller.sv ----
// Power mode sequencer with AHB-Lite register slave
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Notes on behaviour
// - Active: CPU, flash, SRAM, radio, peripherals on
// - Idle gates CPU clock; interrupt returns active
// - Wake latency 14, 151, 1015 us
// - Standby keeps always-powered domain; three wakers
// - Standby wake resumes; retained peripherals kept
// - GPIO latched during standby
// - Shutdown removes all power but pin latches and power-on detector
// - Shutdown latches pins at pre-entry value
// - Shutdown pin edge wakes through reset
// - Reset cause readable in cause register
// - Shutdown keeps only pin latches and power-on detector
// - Reset pin wakes all; held means off
// - Brown-out on, duty-cycled standby, off shutdown
// - Power-on detector active in all modes
// - Crystal doubler enabled for fast clock
// - Internal slow oscillator when no crystal
// - RTC wakes in active, idle, standby
// - Sensor controller wakes only if enabled
module pmc_power_mode_controller
  import pmc_pkg::*;
#(
  parameter int CYC_STANDBY = PMC_CYC_STANDBY,
  parameter int CYC_SHUT    = PMC_CYC_SHUT
) (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Wake sources
  input  wire logic                  irq_any,
  input  wire logic                  rtc_event,
  input  wire logic                  sc_event,
  input  wire logic                  reset_pin_n,
  input  wire logic [PMC_GPIO_W-1:0] io_pin_in,
  input  wire logic [PMC_GPIO_W-1:0] io_wake_sel,
  input  wire logic [PMC_GPIO_W-1:0] io_drive_val,
  input  wire logic                  slow_crystal_fitted,
  // Domain controls
  output logic                       cpu_clk_en,
  output logic                       cpu_run,
  output logic                       flash_pwr,
  output logic                       sram_pwr,
  output logic                       radio_en,
  output logic                       periph_en,
  output logic                       always_powered_domain,
  output logic                       sc_pwr,
  output logic                       brownout_detector,
  output logic                       por_detector_en,
  output logic                       fast_crystal_osc,
  output logic                       doubler_en,
  output logic                       fast_internal_osc,
  output logic                       slow_crystal_osc,
  output logic                       slow_internal_osc,
  output logic                       rtc_en,
  output logic                       io_latch,
  output logic [PMC_GPIO_W-1:0]      io_latched_val,
  output logic                       sys_reset_req,
  output logic                       cpu_resume
);

  // ==========================================================
  // State
  typedef struct packed {
    pmc_mode_t             mode;
    pmc_mode_t             wake_from;
    logic [20:0]           cnt;
    logic [5:0]            bod_cnt;
    logic [2:0]            wake_en;
    logic                  fast_xtal;
    logic [1:0]            cause;
    logic [PMC_GPIO_W-1:0] io_hold;
    logic [PMC_GPIO_W-1:0] io_prev;
    logic                  rst_pulse;
    logic                  resume;
    logic                  dph_wr;
    logic                  dph_rd;
    logic [7:0]            dph_addr;
    logic [31:0]           rdata;
  } pmc_state_t;

  pmc_state_t s_q;
  pmc_state_t s_d;

  function automatic logic [20:0] wake_cycles(input pmc_mode_t m);
    if (m == PMC_IDLE) begin
      wake_cycles = 21'(PMC_CYC_IDLE);
    end else if (m == PMC_STANDBY) begin
      wake_cycles = 21'(CYC_STANDBY);
    end else begin
      wake_cycles = 21'(CYC_SHUT);
    end
  endfunction

  logic            ahb_take;
  logic [1:0]      req;
  logic            io_edge;
  logic            pin_held;

  assign ahb_take = hsel && hready && htrans[1];
  assign pin_held = !reset_pin_n;
  assign io_edge  = |((io_pin_in ^ s_q.io_prev) & io_wake_sel);
  assign req      = hwdata[PMC_CTRL_REQ_LSB +: 2];

  // ==========================================================
  // Next state
  always_comb begin
    s_d           = s_q;
    s_d.rst_pulse = 1'b0;
    s_d.resume    = 1'b0;
    s_d.io_prev   = io_pin_in;
    s_d.dph_wr    = ahb_take && hwrite;
    s_d.dph_rd    = ahb_take && !hwrite;
    if (ahb_take) begin
      s_d.dph_addr = haddr;
    end
    if (s_q.mode == PMC_STANDBY) begin
      s_d.bod_cnt = s_q.bod_cnt + 6'h01;
    end else begin
      s_d.bod_cnt = '0;
    end

    // Register writes land in the data phase
    if (s_q.dph_wr) begin
      if (s_q.dph_addr == PMC_OFS_CTRL && s_q.mode == PMC_ACTIVE) begin
        case (req)
          PMC_REQ_IDLE: begin
            s_d.mode = PMC_IDLE;
          end
          PMC_REQ_STANDBY: begin
            s_d.mode = PMC_STANDBY;
            s_d.io_hold = io_drive_val;
          end
          PMC_REQ_SHUTDOWN: begin
            s_d.mode = PMC_SHUTDOWN;
            s_d.io_hold = io_drive_val;
          end
          default: begin
          end
        endcase
      end else if (s_q.dph_addr == PMC_OFS_WAKEEN) begin
        s_d.wake_en = hwdata[2:0];
      end else if (s_q.dph_addr == PMC_OFS_CLKCFG) begin
        s_d.fast_xtal = hwdata[PMC_CLK_SLOWX_BIT];
      end
    end

    // Sequencer
    case (s_q.mode)
      PMC_IDLE: begin
        if (irq_any || rtc_event
            || (sc_event && s_q.wake_en[PMC_WAKE_SC_BIT])) begin
          s_d.mode      = PMC_WAKING;
          s_d.wake_from = PMC_IDLE;
          s_d.cnt       = wake_cycles(PMC_IDLE);
        end
      end
      PMC_STANDBY: begin
        if ((io_edge && s_q.wake_en[PMC_WAKE_IO_BIT])
            || (rtc_event && s_q.wake_en[PMC_WAKE_RTC_BIT])
            || (sc_event && s_q.wake_en[PMC_WAKE_SC_BIT])) begin
          s_d.mode      = PMC_WAKING;
          s_d.wake_from = PMC_STANDBY;
          s_d.cnt       = wake_cycles(PMC_STANDBY);
        end
      end
      PMC_SHUTDOWN: begin
        if (io_edge) begin
          s_d.mode      = PMC_WAKING;
          s_d.wake_from = PMC_SHUTDOWN;
          s_d.cause     = PMC_CAUSE_IOW;
          s_d.cnt       = wake_cycles(PMC_SHUTDOWN);
        end
      end
      PMC_PIN_HELD: begin
        if (!pin_held) begin
          s_d.mode      = PMC_WAKING;
          s_d.wake_from = PMC_PIN_HELD;
          s_d.cnt       = wake_cycles(PMC_PIN_HELD);
        end
      end
      PMC_WAKING: begin
        if (s_q.cnt <= 21'h00_0001) begin
          s_d.mode = PMC_ACTIVE;
          s_d.cnt  = '0;
          // Reset wake loses wake enables and clock choice; resume keeps them
          if (s_q.wake_from == PMC_SHUTDOWN
              || s_q.wake_from == PMC_PIN_HELD) begin
            s_d.rst_pulse = 1'b1;
            s_d.wake_en   = PMC_WAKEEN_RST;
            s_d.fast_xtal = 1'b0;
          end else begin
            s_d.resume = 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt - 21'h00_0001;
        end
      end
      default: begin
      end
    endcase

    // Pin reset overrides every mode
    if (pin_held) begin
      s_d.mode  = PMC_PIN_HELD;
      s_d.cause = PMC_CAUSE_PIN;
    end

    if (s_q.dph_rd) begin
      s_d.rdata = '0;
    end
    if (ahb_take && !hwrite) begin
      if (haddr == PMC_OFS_CTRL) begin
        s_d.rdata = '0;
      end else if (haddr == PMC_OFS_STATUS) begin
        s_d.rdata = {29'h0, s_q.mode};
      end else if (haddr == PMC_OFS_WAKEEN) begin
        s_d.rdata = {29'h0, s_q.wake_en};
      end else if (haddr == PMC_OFS_CAUSE) begin
        s_d.rdata = {30'h0, s_q.cause};
      end else if (haddr == PMC_OFS_CLKCFG) begin
        s_d.rdata = {31'h0, s_q.fast_xtal};
      end else begin
        s_d.rdata = '0;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q           <= '0;
      s_q.mode      <= PMC_ACTIVE;
      s_q.wake_from <= PMC_ACTIVE;
      s_q.wake_en   <= PMC_WAKEEN_RST;
      s_q.cause     <= PMC_CAUSE_POR;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Domain outputs
  logic act;
  logic act_idle;
  logic warm;
  logic live;
  assign act      = s_q.mode == PMC_ACTIVE;
  assign act_idle = act || s_q.mode == PMC_IDLE;
  // Resume-type wake keeps retention supplies; dropping them loses SRAM
  assign warm     = s_q.mode == PMC_WAKING
                    && (s_q.wake_from == PMC_IDLE
                        || s_q.wake_from == PMC_STANDBY);
  assign live     = act_idle || s_q.mode == PMC_STANDBY || warm;

  assign cpu_clk_en = act;
  assign cpu_run    = act;
  assign flash_pwr  = act_idle;
  assign sram_pwr   = live;
  assign radio_en   = act_idle;
  assign periph_en  = act_idle;
  assign always_powered_domain = live;
  assign sc_pwr     = live;
  assign rtc_en     = live;
  // Standby samples brown-out one cycle in each period
  assign brownout_detector = act_idle
                             || (s_q.mode == PMC_STANDBY
                                 && s_q.bod_cnt == 6'h00);
  assign por_detector_en   = 1'b1;
  assign fast_crystal_osc  = act_idle && s_q.fast_xtal;
  assign doubler_en        = fast_crystal_osc;
  assign fast_internal_osc = act_idle && !s_q.fast_xtal;
  assign slow_crystal_osc  = live && slow_crystal_fitted;
  assign slow_internal_osc = live && !slow_crystal_fitted;
  assign io_latch = s_q.mode == PMC_STANDBY
                    || s_q.mode == PMC_SHUTDOWN;
  assign io_latched_val = s_q.io_hold;
  assign sys_reset_req  = s_q.rst_pulse || s_q.mode == PMC_PIN_HELD;
  assign cpu_resume     = s_q.resume;

  assign hrdata    = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule

// ---- pmc_pkg.sv ----
// Package for the power mode controller: modes, register map, timing
package pmc_pkg;

  typedef enum logic [2:0] {
    PMC_ACTIVE,
    PMC_IDLE,
    PMC_STANDBY,
    PMC_SHUTDOWN,
    PMC_PIN_HELD,
    PMC_WAKING
  } pmc_mode_t;

  // Mode request codes written by software
  localparam logic [1:0] PMC_REQ_IDLE     = 2'h1;
  localparam logic [1:0] PMC_REQ_STANDBY  = 2'h2;
  localparam logic [1:0] PMC_REQ_SHUTDOWN = 2'h3;

  // Reset cause codes
  localparam logic [1:0] PMC_CAUSE_POR = 2'h0;
  localparam logic [1:0] PMC_CAUSE_PIN = 2'h1;
  localparam logic [1:0] PMC_CAUSE_IOW = 2'h2;

  // Register byte offsets
  localparam logic [7:0] PMC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] PMC_OFS_STATUS = 8'h04;
  localparam logic [7:0] PMC_OFS_WAKEEN = 8'h08;
  localparam logic [7:0] PMC_OFS_CAUSE  = 8'h0C;
  localparam logic [7:0] PMC_OFS_CLKCFG = 8'h10;

  // Field positions
  localparam int PMC_CTRL_REQ_LSB  = 0;
  localparam int PMC_WAKE_IO_BIT   = 0;
  localparam int PMC_WAKE_RTC_BIT  = 1;
  localparam int PMC_WAKE_SC_BIT   = 2;
  localparam int PMC_CLK_SLOWX_BIT = 0;

  localparam logic [2:0]  PMC_WAKEEN_RST = 3'h7;
  localparam int          PMC_GPIO_W     = 16;
  localparam int          PMC_BOD_PERIOD = 64;

  // Wake latencies in ns, and derived clock counts
  localparam int PMC_CLK_NS       = 50;
  localparam int PMC_T_IDLE_NS    = 14000;
  localparam int PMC_T_STANDBY_NS = 151000;
  localparam int PMC_T_SHUT_NS    = 1015000;
  localparam int PMC_CYC_IDLE     = PMC_T_IDLE_NS / PMC_CLK_NS;
  localparam int PMC_CYC_STANDBY  = PMC_T_STANDBY_NS / PMC_CLK_NS;
  localparam int PMC_CYC_SHUT     = PMC_T_SHUT_NS / PMC_CLK_NS;

endpackage

// ---- pmc_checker_asserts.sv ----
// Concurrent checks on the power mode controller ports
`timescale 1ns/1ps
module pmc_checker
  import pmc_pkg::*;
(
  // Clock, reset and bus answer
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  // Wake side inputs
  input wire logic                  reset_pin_n,
  input wire logic                  slow_crystal_fitted,
  // Domain controls
  input wire logic                  cpu_clk_en,
  input wire logic                  cpu_run,
  input wire logic                  flash_pwr,
  input wire logic                  sram_pwr,
  input wire logic                  always_powered_domain,
  input wire logic                  sc_pwr,
  input wire logic                  brownout_detector,
  input wire logic                  por_detector_en,
  input wire logic                  fast_crystal_osc,
  input wire logic                  doubler_en,
  input wire logic                  fast_internal_osc,
  input wire logic                  slow_crystal_osc,
  input wire logic                  slow_internal_osc,
  input wire logic                  rtc_en,
  input wire logic                  io_latch,
  input wire logic [PMC_GPIO_W-1:0] io_latched_val,
  input wire logic                  cpu_resume
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic stby = io_latch && always_powered_domain;
  wire logic shut = io_latch && !always_powered_domain;
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus wait or error");
  por_on_a: assert property (por_detector_en)
    else $error("por detector off");
  run_powered_a: assert property (cpu_run |-> cpu_clk_en && flash_pwr && sram_pwr)
    else $error("cpu runs unpowered");
  pin_held_a: assert property (!reset_pin_n [*2] |-> !cpu_run && !rtc_en && !sc_pwr)
    else $error("function alive while pin held");
  shut_dark_a: assert property (shut |-> !brownout_detector && !sc_pwr && !rtc_en
    && !slow_crystal_osc && !slow_internal_osc && !fast_internal_osc)
    else $error("power left on in shutdown");
  stby_clocks_a: assert property (stby |-> !fast_crystal_osc && !fast_internal_osc
    && (slow_crystal_osc || slow_internal_osc))
    else $error("standby clocks wrong");
  bod_duty_a: assert property (stby && brownout_detector ##1 stby |-> !brownout_detector)
    else $error("brownout not duty cycled");
  doubler_on_a: assert property (doubler_en == fast_crystal_osc)
    else $error("doubler mismatch");
  slow_pick_a: assert property (!slow_crystal_fitted [*2] ##0
    (slow_crystal_osc || slow_internal_osc) |-> slow_internal_osc)
    else $error("internal slow osc not used");
  latch_hold_a: assert property (io_latch && $past(io_latch) |-> $stable(io_latched_val))
    else $error("latched pins moved");
  resume_pulse_a: assert property (cpu_resume |=> !cpu_resume)
    else $error("resume not a pulse");
endmodule
bind pmc_power_mode_controller pmc_checker pmc_checker_i (.*);

// ---- tb_power_mode_controller.sv ----
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
module tb_power_mode_controller;
  import pmc_pkg::*;
  localparam int NSB = 20;
  localparam int NSH = 40;
  logic hclk, hresetn, hsel, hwrite, irq_any, rtc_event, sc_event;
  logic reset_pin_n, slow_crystal_fitted, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] io_pin_in, io_wake_sel, io_drive_val, io_latched_val, drv;
  logic cpu_clk_en, cpu_run, flash_pwr, sram_pwr, radio_en, periph_en;
  logic always_powered_domain, sc_pwr, brownout_detector, por_detector_en;
  logic fast_crystal_osc, doubler_en, fast_internal_osc, slow_crystal_osc;
  logic slow_internal_osc, rtc_en, io_latch, sys_reset_req, cpu_resume;
  wire logic hready = hreadyout;
  int error_cnt = 0, checks = 0, cyc = 0, seed = 90, n;
  pmc_power_mode_controller #(.CYC_STANDBY(NSB), .CYC_SHUT(NSH))
    pmc_power_mode_controller_i (.*);
  always #25 hclk = ~hclk;
  // ==========================================
  // Helpers
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  // One single transfer; caller sits just after an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, rd, e);
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask
  task automatic wt(ref logic s, output int c);
    c = 0;
    while (s !== 1'b1 && c < 2000) begin
      step(1);
      c++;
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {hclk, hresetn, hsel, hwrite, irq_any, rtc_event, sc_event} = '0;
    {haddr, htrans, hwdata, io_pin_in, io_wake_sel, io_drive_val} = '0;
    hsize = 3'h2;
    reset_pin_n = 1'b1;
    slow_crystal_fitted = 1'b0;
    step(4);
    hresetn <= 1'b1;
    step(1);
    rdchk("mode", PMC_OFS_STATUS, PMC_ACTIVE);
    rdchk("cause", PMC_OFS_CAUSE, PMC_CAUSE_POR);
    rdchk("wakeen", PMC_OFS_WAKEEN, PMC_WAKEEN_RST);
    rdchk("unmapped", 8'h20, 32'h0000_0000);
    bus(1'b1, PMC_OFS_CLKCFG, 32'h0000_0001);
    chk("fast osc", fast_crystal_osc, 1'b1);
    slow_crystal_fitted <= 1'($random(seed));
    chk("active", {cpu_run, flash_pwr, radio_en, periph_en}, 4'hF);
    bus(1'b1, PMC_OFS_CTRL, PMC_REQ_IDLE);
    step(1);
    rdchk("idle", PMC_OFS_STATUS, PMC_IDLE);
    chk("idle clk", {cpu_clk_en, periph_en}, 2'b01);
    step(1 + ($random(seed) & 7));
    rdchk("no self", PMC_OFS_STATUS, PMC_IDLE);
    irq_any <= 1'b1;
    step(2);
    chk("wake sram", {sram_pwr, cpu_run}, 2'b10);
    wt(cpu_resume, n);
    chk("idle lat", n >= PMC_CYC_IDLE - 2 && n <= PMC_CYC_IDLE + 1, 1);
    irq_any <= 1'b0;
    step(1);
    chk("resumed", cpu_run, 1'b1);
    for (int i = 0; i < 2; i++) begin
      io_drive_val <= 16'($random(seed));
      bus(1'b1, PMC_OFS_WAKEEN, i ? 32'h0000_0002 : 32'h0000_0004);
      bus(1'b1, PMC_OFS_CTRL, PMC_REQ_STANDBY);
      step(1);
      chk("stby latch", io_latch, 1'b1);
      {rtc_event, sc_event} <= i ? 2'b01 : 2'b10;
      step(3);
      {rtc_event, sc_event} <= 2'b00;
      rdchk("stby", PMC_OFS_STATUS, PMC_STANDBY);
      {rtc_event, sc_event} <= i ? 2'b10 : 2'b01;
      wt(cpu_resume, n);
      chk("stby lat", n >= NSB && n <= NSB + 3, 1);
      {rtc_event, sc_event} <= 2'b00;
      step(2);
    end
    drv = 16'($random(seed));
    io_drive_val <= drv;
    io_wake_sel <= 16'h0010;
    bus(1'b1, PMC_OFS_CTRL, PMC_REQ_SHUTDOWN);
    step(1);
    io_drive_val <= ~drv;
    io_pin_in <= 16'h0001;
    step(5);
    chk("shut latch", io_latched_val, drv);
    chk("aon off", always_powered_domain, 1'b0);
    io_pin_in <= 16'h0011;
    wt(sys_reset_req, n);
    chk("shut lat", n >= NSH && n <= NSH + 3, 1);
    step(2);
    rdchk("io cause", PMC_OFS_CAUSE, PMC_CAUSE_IOW);
    rdchk("wakeen lost", PMC_OFS_WAKEEN, PMC_WAKEEN_RST);
    rdchk("clkcfg lost", PMC_OFS_CLKCFG, 32'h0000_0000);
    bus(1'b1, PMC_OFS_CTRL, PMC_REQ_IDLE);
    reset_pin_n <= 1'b0;
    step(4);
    chk("held", {sys_reset_req, cpu_run}, 2'b10);
    reset_pin_n <= 1'b1;
    wt(cpu_run, n);
    chk("pin lat", n >= NSH && n <= NSH + 4, 1);
    step(2);
    rdchk("pin cause", PMC_OFS_CAUSE, PMC_CAUSE_PIN);
    stop_test();
  end
endmodule
